// *** rtm_defs.svh ***
// Constants for the tag transmit controller and its programming port
//
// Overview of operation
// - A frame carries exactly 154 stored bits, each Manchester encoded.
// - After a frame's last bit the tag sleeps about 100 ms.
// - Frames and sleeps alternate forever without any trigger while powered.
// - Only antenna output is the switch; high cloaks, low uncloaks the antenna.
// - Manchester rate is nominally 70 kHz, timed from the internal clock.
// - Sleep timer free-runs, unsynchronised to reader or other tags.
// - No commands or writes in field use; only contact programming writes.
// - Every one of the 154 bits can be erased and rewritten by contact.
// - Data pad is input while programming and drives data in read test.
// - Clock and data pads read low when left undriven.
// - One is uncloaked, cloaked; zero is cloaked, uncloaked; halves ~7 us.
// - Switch stays on, antenna cloaked, for the whole sleep interval.
// - Logic held in reset until supply is good, runs only after release.
`ifndef RTM_DEFS_SVH
`define RTM_DEFS_SVH

`define RTM_CLK_HZ 100000000
`define RTM_FRAME_BITS 154
`define RTM_ADDR_W 8
`define RTM_MOD_HZ 70000
`define RTM_HALF_CYC (`RTM_CLK_HZ / (2 * `RTM_MOD_HZ))
`define RTM_HALF_W 10
`define RTM_SLEEP_MS 100
`define RTM_SLEEP_CYC ((`RTM_CLK_HZ / 1000) * `RTM_SLEEP_MS)
`define RTM_SLEEP_W 24

`define RTM_MOD_RST 1'h1
`define RTM_ERASED_BIT 1'h0

`define RTM_CODE_LEN 10
`define RTM_CODE_CNT_W 4
`define RTM_CODE_ERASE 10'h1D4
`define RTM_CODE_PROG 10'h1D2
`define RTM_CODE_READ 10'h1D6

`endif

// *** rtm_pkg.sv ***
// Types shared by the tag transmit controller
`default_nettype none
package rtm_pkg;

  typedef enum logic [1:0] {
    RTM_TX_FIRST = 2'b00,
    RTM_TX_SECOND = 2'b01,
    RTM_TX_SLEEP = 2'b10
  } rtm_tx_state_t;

  typedef enum logic [1:0] {
    RTM_PM_CODE = 2'b00,
    RTM_PM_ERASE = 2'b01,
    RTM_PM_PROG = 2'b10,
    RTM_PM_READ = 2'b11
  } rtm_pmode_t;

endpackage
`default_nettype wire

// *** rtm_store.sv ***
// Non-volatile bit store with one write port and two read ports
`timescale 1ns/10ps
`default_nettype none
module rtm_store #(
  parameter int DEPTH = 154,
  parameter int AW = 8,
  parameter logic [DEPTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic rd_b_data
);

  // Contents survive reset, as the cells would
  logic [DEPTH-1:0] mem_q = INIT;

  always_ff @(posedge clk) begin
    if (wr_en && (wr_addr < AW'(DEPTH))) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    rd_a_data = 1'h0;
    rd_b_data = 1'h0;
    if (rd_a_addr < AW'(DEPTH)) begin
      rd_a_data = mem_q[rd_a_addr];
    end
    if (rd_b_addr < AW'(DEPTH)) begin
      rd_b_data = mem_q[rd_b_addr];
    end
  end

endmodule
`default_nettype wire

// *** rtm_tag_tx.sv ***
// Tag transmit controller: Manchester frames, sleep timer, contact port
`timescale 1ns/10ps
`default_nettype none
`include "rtm_defs.svh"
module rtm_tag_tx
  import rtm_pkg::*;
#(
  parameter int FRAME_BITS = `RTM_FRAME_BITS,
  parameter int HALF_CYC = `RTM_HALF_CYC,
  parameter int SLEEP_CYC = `RTM_SLEEP_CYC,
  parameter logic [`RTM_FRAME_BITS-1:0] STORE_INIT = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic mod_on_q,
  output logic frame_active_q,
  input wire logic prg_clk_pad_i,
  input wire logic prg_data_pad_i,
  output logic prg_data_pad_o_q,
  output logic prg_data_pad_oe_q,
  input wire logic prg_hv_i,
  output logic prg_busy_q
);

  localparam int AW = `RTM_ADDR_W;
  localparam int HW = `RTM_HALF_W;
  localparam int SW = `RTM_SLEEP_W;
  localparam int CW = `RTM_CODE_CNT_W;
  localparam int CL = `RTM_CODE_LEN;

  // Transmit side
  rtm_tx_state_t state_q;
  logic [HW-1:0] half_cnt_q;
  logic [SW-1:0] sleep_cnt_q;
  logic [AW-1:0] bit_idx_q;
  logic tx_bit;
  logic half_done;
  logic sleep_done;
  logic last_bit;
  logic sym_start;
  logic sym_bit;
  logic bit_hold_q;

  assign half_done = (half_cnt_q == HW'(HALF_CYC - 1));
  assign sleep_done = (sleep_cnt_q == SW'(SLEEP_CYC - 1));
  assign last_bit = (bit_idx_q == AW'(FRAME_BITS - 1));

  // Sequencer; no input other than the clock and reset can move it, so the
  // reader cannot command or trigger anything here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= RTM_TX_FIRST;
    end else begin
      unique case (state_q)
        RTM_TX_FIRST: begin
          if (half_done) begin
            state_q <= RTM_TX_SECOND;
          end
        end
        RTM_TX_SECOND: begin
          if (half_done && last_bit) begin
            state_q <= RTM_TX_SLEEP;
          end else if (half_done) begin
            state_q <= RTM_TX_FIRST;
          end
        end
        RTM_TX_SLEEP: begin
          if (sleep_done) begin
            state_q <= RTM_TX_FIRST;
          end
        end
        default: begin
          state_q <= RTM_TX_FIRST;
        end
      endcase
    end
  end

  // Half-bit timer, idle while asleep
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half_cnt_q <= '0;
    end else if (state_q == RTM_TX_SLEEP || half_done) begin
      half_cnt_q <= '0;
    end else begin
      half_cnt_q <= half_cnt_q + HW'(1);
    end
  end

  // Free-running sleep timer: no reader or neighbour can align it, so
  // slot spread between tags comes only from their oscillators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleep_cnt_q <= '0;
    end else if (state_q != RTM_TX_SLEEP || sleep_done) begin
      sleep_cnt_q <= '0;
    end else begin
      sleep_cnt_q <= sleep_cnt_q + SW'(1);
    end
  end

  // Bit pointer: every frame restarts from the first stored bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_idx_q <= '0;
    end else if (state_q == RTM_TX_SECOND && half_done) begin
      if (last_bit) begin
        bit_idx_q <= '0;
      end else begin
        bit_idx_q <= bit_idx_q + AW'(1);
      end
    end
  end

  // Cell read once per symbol: contact writes go on while frames run,
  // and a cell changed between halves would break the pair
  assign sym_start = (state_q == RTM_TX_FIRST) && (half_cnt_q == '0);
  assign sym_bit = sym_start ? tx_bit : bit_hold_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_hold_q <= 1'h0;
    end else begin
      bit_hold_q <= sym_bit;
    end
  end

  // Switch drive; one cycle behind the state, equally for every half.
  // Held cloaked in reset so a weak supply never shows a tuned tag.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mod_on_q <= `RTM_MOD_RST;
    end else begin
      unique case (state_q)
        RTM_TX_FIRST: mod_on_q <= ~sym_bit;
        RTM_TX_SECOND: mod_on_q <= sym_bit;
        RTM_TX_SLEEP: mod_on_q <= 1'h1;
        default: mod_on_q <= 1'h1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_active_q <= 1'h0;
    end else begin
      frame_active_q <= (state_q != RTM_TX_SLEEP);
    end
  end

  // Contact programming side
  // Pads are asynchronous to the oscillator; first stages feed only
  // the second. Undriven pads are pulled low outside, so an idle pad
  // reads as 0 and never shifts a one into the mode code.
  logic ck_s1_q;
  logic ck_s2_q;
  logic ck_s3_q;
  logic dt_s1_q;
  logic dt_s2_q;
  logic hv_s1_q;
  logic hv_s2_q;
  logic hv_s3_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_s1_q <= 1'h0;
      ck_s2_q <= 1'h0;
      ck_s3_q <= 1'h0;
    end else begin
      ck_s1_q <= prg_clk_pad_i;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dt_s1_q <= 1'h0;
      dt_s2_q <= 1'h0;
    end else begin
      dt_s1_q <= prg_data_pad_i;
      dt_s2_q <= dt_s1_q;
    end
  end

  // Third stage only keeps the last level for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hv_s1_q <= 1'h0;
      hv_s2_q <= 1'h0;
      hv_s3_q <= 1'h0;
    end else begin
      hv_s1_q <= prg_hv_i;
      hv_s2_q <= hv_s1_q;
      hv_s3_q <= hv_s2_q;
    end
  end

  logic ck_rise;
  logic hv_rise;
  logic exit_req;

  // Pad clock at 500 kHz or less gives 100 cycles per phase here
  assign ck_rise = ck_s2_q & ~ck_s3_q;
  assign hv_rise = hv_s2_q & ~hv_s3_q;
  // Exit: clock pad already high when the high voltage arrives
  assign exit_req = hv_rise & ck_s2_q;

  rtm_pmode_t pmode_q;
  logic [CL-1:0] code_q;
  logic [CW-1:0] code_cnt_q;
  logic [AW-1:0] paddr_q;
  logic [CL-1:0] code_next;
  logic code_full;

  assign code_next = {code_q[CL-2:0], dt_s2_q};
  assign code_full = (code_cnt_q >= CW'(CL - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmode_q <= RTM_PM_CODE;
    end else if (exit_req) begin
      pmode_q <= RTM_PM_CODE;
    end else if (pmode_q == RTM_PM_CODE && ck_rise && code_full) begin
      if (code_next == `RTM_CODE_ERASE) begin
        pmode_q <= RTM_PM_ERASE;
      end else if (code_next == `RTM_CODE_PROG) begin
        pmode_q <= RTM_PM_PROG;
      end else if (code_next == `RTM_CODE_READ) begin
        pmode_q <= RTM_PM_READ;
      end
    end
  end

  // Code shifter, first bit entered ends up most significant
  always_ff @(posedge clk) begin
    if (sys_rst || exit_req || pmode_q != RTM_PM_CODE) begin
      code_q <= '0;
    end else if (ck_rise) begin
      code_q <= code_next;
    end
  end

  // Count saturates, so a long run of noise keeps sliding the shifter
  always_ff @(posedge clk) begin
    if (sys_rst || exit_req || pmode_q != RTM_PM_CODE) begin
      code_cnt_q <= '0;
    end else if (ck_rise && !code_full) begin
      code_cnt_q <= code_cnt_q + CW'(1);
    end
  end

  // Cell pointer steps once per pad clock and stops past the last cell
  always_ff @(posedge clk) begin
    if (sys_rst || pmode_q == RTM_PM_CODE) begin
      paddr_q <= '0;
    end else if (ck_rise && paddr_q < AW'(FRAME_BITS)) begin
      paddr_q <= paddr_q + AW'(1);
    end
  end

  logic wr_mode;
  logic wr_en;
  logic wr_data;
  logic rd_bit;

  // Writes only exist behind a contact mode code; the cell write is
  // done in one cycle, well inside the time the programmer leaves
  assign wr_mode = (pmode_q == RTM_PM_ERASE) || (pmode_q == RTM_PM_PROG);
  assign wr_en = ck_rise && !exit_req && wr_mode;
  assign wr_data = (pmode_q == RTM_PM_PROG) ? dt_s2_q : `RTM_ERASED_BIT;

  rtm_store #(
    .DEPTH(FRAME_BITS),
    .AW(AW),
    .INIT(STORE_INIT)
  ) u_store (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(paddr_q),
    .wr_data(wr_data),
    .rd_a_addr(bit_idx_q),
    .rd_a_data(tx_bit),
    .rd_b_addr(paddr_q),
    .rd_b_data(rd_bit)
  );

  // Data pad turns round only in read test
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prg_data_pad_oe_q <= 1'h0;
    end else begin
      prg_data_pad_oe_q <= (pmode_q == RTM_PM_READ);
    end
  end

  // Value held low while released, so no stale bit waits on the pad
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prg_data_pad_o_q <= 1'h0;
    end else if (pmode_q == RTM_PM_READ) begin
      prg_data_pad_o_q <= rd_bit;
    end else begin
      prg_data_pad_o_q <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prg_busy_q <= 1'h0;
    end else begin
      prg_busy_q <= (pmode_q != RTM_PM_CODE);
    end
  end

endmodule
`default_nettype wire

// *** rtm_tag_tx_props.sv ***
// Port checker for the tag transmit controller
`timescale 1ns/10ps
`default_nettype none
module rtm_tag_tx_props #(
  parameter int FRAME_BITS = 154,
  parameter int HALF_CYC = 4,
  parameter int SLEEP_CYC = 200
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mod_on_q,
  input wire logic frame_active_q,
  input wire logic prg_data_pad_o_q,
  input wire logic prg_data_pad_oe_q,
  input wire logic prg_busy_q
);
  int fc_q;
  int sc_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    fc_q <= (sys_rst || !frame_active_q) ? 0 : fc_q + 1;
  end
  always_ff @(posedge clk) begin
    sc_q <= (sys_rst || frame_active_q) ? 0 : sc_q + 1;
  end
  // Gap out of reset before the first frame is short, so skip it
  always_ff @(posedge clk) begin
    seen_q <= sys_rst ? 1'h0 : (seen_q | frame_active_q);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_cloak_a: assert property ($fell(sys_rst) |->
    mod_on_q && !frame_active_q && !prg_busy_q) else $error("reset state");
  first_frame_a: assert property ($fell(sys_rst) |=> frame_active_q)
    else $error("no frame after reset");
  sleep_cloak_a: assert property (!frame_active_q |-> mod_on_q)
    else $error("uncloaked in sleep");
  mid_flip_a: assert property (frame_active_q &&
    fc_q % (2 * HALF_CYC) == HALF_CYC |-> mod_on_q != $past(mod_on_q))
    else $error("no mid-bit edge");
  edge_grid_a: assert property (frame_active_q &&
    $changed(mod_on_q) |-> fc_q % HALF_CYC == 0) else $error("edge off grid");
  frame_len_a: assert property ($fell(frame_active_q) |->
    fc_q == 2 * HALF_CYC * FRAME_BITS) else $error("frame length");
  sleep_len_a: assert property ($rose(frame_active_q) && seen_q |->
    sc_q == SLEEP_CYC) else $error("sleep length");
  oe_busy_a: assert property (prg_data_pad_oe_q |-> prg_busy_q)
    else $error("pad driven while idle");
  o_quiet_a: assert property (!prg_data_pad_oe_q |-> !prg_data_pad_o_q)
    else $error("pad value while released");
  cover property ($fell(frame_active_q));
  cover property ($rose(prg_busy_q));
  cover property ($rose(prg_data_pad_oe_q));
endmodule
bind rtm_tag_tx rtm_tag_tx_props #(.FRAME_BITS(FRAME_BITS),
  .HALF_CYC(HALF_CYC), .SLEEP_CYC(SLEEP_CYC)) u_props (.clk(clk),
  .sys_rst(sys_rst), .mod_on_q(mod_on_q), .frame_active_q(frame_active_q),
  .prg_data_pad_o_q(prg_data_pad_o_q), .prg_busy_q(prg_busy_q),
  .prg_data_pad_oe_q(prg_data_pad_oe_q));
`default_nettype wire

// *** rtm_reader.sv ***
// Reader model that decodes the tag's load modulation
`timescale 1ns/10ps
`default_nettype none
module rtm_reader #(
  parameter int HALF = 4,
  parameter int BITS = 154
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mod_on,
  input wire logic active,
  output logic [BITS-1:0] bits_q,
  output logic [15:0] frames_q,
  output logic [15:0] errs_q
);
  int pos_q;
  logic h1_q;
  always_ff @(posedge clk) begin
    pos_q <= (sys_rst || !active) ? 0 : pos_q + 1;
  end
  // Sample mid-half, clear of the switching edges
  always_ff @(posedge clk) begin
    if (active && pos_q % (2 * HALF) == HALF / 2) begin
      h1_q <= mod_on;
    end
    if (active && pos_q % (2 * HALF) == HALF + HALF / 2) begin
      bits_q[pos_q / (2 * HALF)] <= mod_on;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errs_q <= 16'h0;
      frames_q <= 16'h0;
    end else if (active) begin
      if (pos_q % (2 * HALF) == HALF + HALF / 2 && h1_q == mod_on) begin
        errs_q <= errs_q + 16'h1;
      end
      if (pos_q == 2 * HALF * BITS - 1) begin
        frames_q <= frames_q + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtm_tag_tx_tb.sv ***
// Testbench for the tag transmit controller
`timescale 1ns/10ps
`default_nettype none
module rtm_tag_tx_tb;
  localparam int H = 4;
  localparam int S = 200;
  localparam int N = 154;
  localparam logic [153:0] P0 = {11{14'h2C5B}};
  localparam logic [153:0] P1 = {14{11'h4D3}};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic pck = 1'h0;
  logic pdr = 1'h0;
  logic pen = 1'h0;
  logic hv = 1'h0;
  logic mod_on, act, po, poe, busy, pad;
  logic [153:0] rbits;
  logic [15:0] rfr, rerr;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  assign pad = poe ? po : (pen & pdr);
  rtm_tag_tx #(.HALF_CYC(H), .SLEEP_CYC(S), .STORE_INIT(P0)) dut (
    .clk(clk), .sys_rst(sys_rst), .mod_on_q(mod_on),
    .frame_active_q(act), .prg_clk_pad_i(pck), .prg_data_pad_i(pad),
    .prg_data_pad_o_q(po), .prg_data_pad_oe_q(poe), .prg_hv_i(hv),
    .prg_busy_q(busy));
  rtm_reader #(.HALF(H), .BITS(N)) rdr (.clk(clk), .sys_rst(sys_rst),
    .mod_on(mod_on), .active(act), .bits_q(rbits), .frames_q(rfr),
    .errs_q(rerr));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(logic [153:0] seen, logic [153:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Cells commit at once, so no long write wait per rise
  task automatic pclk(logic d);
    pdr = d;
    step(100);
    pck = 1'h1;
    step(100);
    pck = 1'h0;
  endtask
  task automatic code(logic [9:0] c);
    pen = 1'h1;
    for (int i = 9; i >= 0; i--) pclk(c[i]);
  endtask
  task automatic leave();
    step(100);
    pck = 1'h1;
    step(50);
    hv = 1'h1;
    step(50);
    hv = 1'h0;
    pck = 1'h0;
    pen = 1'h0;
    step(10);
    chk(154'(busy), '0);
  endtask
  task automatic frames(int n);
    logic [15:0] f;
    f = rfr;
    for (int i = 0; i < 9999 && rfr < f + n; i++) step(1);
    chk(154'(rfr >= f + n), 154'h1);
  endtask
  task automatic t_tx();
    int n;
    frames(2);
    chk(rbits, P0);
    chk(154'(rfr > 1), 154'h1);
    for (int i = 0; i < 99 && act !== 1'h0; i++) step(1);
    n = 0;
    while (act === 1'h0 && mod_on === 1'h1 && n < 999) begin
      n++;
      step(1);
    end
    chk(154'(n), 154'(S));
    chk(154'(rerr), '0);
    $display("frame test done");
  endtask
  task automatic t_prog();
    code(10'h1D2);
    chk(154'(busy), 154'h1);
    for (int i = 0; i < N; i++) pclk(P1[i]);
    leave();
    frames(2);
    chk(rbits, P1);
    chk(154'(rerr), '0);
    $display("program test done");
  endtask
  task automatic t_read();
    code(10'h1D6);
    pen = 1'h0;
    chk(154'(poe), 154'h1);
    for (int i = 0; i < 16; i++) begin
      chk(154'(pad), 154'(P1[i]));
      pclk(1'h0);
    end
    leave();
    $display("read test done");
  endtask
  task automatic t_erase();
    code(10'h1D4);
    for (int i = 0; i < N; i++) pclk(1'h1);
    leave();
    frames(2);
    chk(rbits, '0);
    $display("erase test done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    step(11);
    chk(154'({mod_on, act, poe, busy}), 154'h8);
    $display("reset test done");
    step(1);
    sys_rst = 1'h0;
    t_tx();
    t_prog();
    t_read();
    t_erase();
    summarize();
  end
endmodule
`default_nettype wire
